// ===== clip_port.sv
// Instruction port and command decoder of a character display controller
// Function
// - Clear fills display memory with 20H, address to 00H, busy 1.53 ms.
// - Return home zeroes address and display shift, memory kept, busy 1.53 ms.
// - Entry mode stores direction and whole-display shift enable, 39 us.
// - Display control stores display, cursor and blink bits, 39 us.
// - Shift moves cursor or display, direction given, memory untouched, 39 us.
// - Function set latches bus width, line count and font, 39 us.
// - Glyph address loads 6 bits into counter, selects glyph memory, 39 us.
// - Display address loads 7 bits into counter, selects display memory, 39 us.
// - Status read drives busy indication on DB7 with no execution time.
// - Status read shows address counter on DB6..DB0.
// - Data write stores byte into selected memory, 43 us.
// - Data read returns byte from selected memory, 43 us.
// - Eight-bit mode moves a byte per enable cycle on DB0..DB7.
// - Four-bit mode uses DB4..DB7 only, lower lines ignored.
// - Four-bit mode moves upper nibble first, then lower nibble.
// - Four-bit mode starts execution only after the second nibble.
// - Width bit set selects eight-bit mode, clear selects four-bit mode.
// - Each data access steps address counter by one per entry direction.
// - Two-line mode uses 00H-27H and 40H-67H.
`timescale 1ns/1ps
module clip_port #(
    parameter int LONG_CYCLES = clip_pkg::LONG_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Host bus
    input wire logic bus_en,
    input wire logic reg_select,
    input wire logic read_write,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // Status and display control
    output logic busy_indication,
    output logic [6:0] address_counter,
    output logic glyph_sel,
    output logic bus_width_sel,
    output logic incr_dir,
    output logic whole_display_shift_en,
    output logic display_on,
    output logic cursor_on,
    output logic blink_on,
    output logic two_line,
    output logic font_sel,
    output logic [6:0] display_shift
);

    initial begin
        // Clear needs its 128 fill cycles inside the busy time
        if (LONG_CYCLES < 130 || LONG_CYCLES > 65535) begin
            $error("LONG_CYCLES out of range");
        end
    end

    localparam logic [15:0] LONG_N = 16'(LONG_CYCLES);
    localparam logic [15:0] SHORT_N = 16'(clip_pkg::SHORT_CYCLES);
    localparam logic [15:0] DATA_N = 16'(clip_pkg::DATA_CYCLES);

    typedef struct packed {
        logic en;
        logic nib_phase;
        logic [3:0] hi_nib;
        clip_pkg::clip_exec_t exec;
        logic [15:0] cnt;
        logic [6:0] fill_ptr;
        logic [6:0] ac;
        logic glyph;
        logic incr;
        logic sh_en;
        logic disp_on;
        logic cur_on;
        logic blink;
        logic bw8;
        logic lines2;
        logic font;
        logic [6:0] shift;
        logic [7:0] dout;
        logic oe_n;
    } clip_state_t;

    clip_state_t s_q, s_d;
    logic [7:0] ram_rdata;
    logic [7:0] ram_addr;
    logic ram_we;
    logic [7:0] ram_wdata;
    logic fall;
    logic done;
    logic [7:0] byte_v;
    logic [7:0] rd_val;
    logic busy;

    // ==========================================================
    // Address stepping
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                             input logic glyph, input logic lines2);
        logic [6:0] r;
        r = up ? a + 7'h01 : a - 7'h01;
        if (glyph) begin
            r = {1'b0, r[5:0]};
        end else if (lines2) begin
            if (up && a == clip_pkg::LINE1_END) r = clip_pkg::LINE2_BASE;
            else if (up && a == clip_pkg::LINE2_END) r = clip_pkg::ADDR_HOME;
            else if (!up && a == clip_pkg::LINE2_BASE) r = clip_pkg::LINE1_END;
            else if (!up && a == clip_pkg::ADDR_HOME) r = clip_pkg::LINE2_END;
        end else begin
            if (up && a == clip_pkg::ONE_LINE_END) r = clip_pkg::ADDR_HOME;
            else if (!up && a == clip_pkg::ADDR_HOME) r = clip_pkg::ONE_LINE_END;
        end
        return r;
    endfunction : step_addr

    // ==========================================================
    // Memory
    clip_ram #(.AW(8), .DW(8)) u_ram (
        .sys_clk(sys_clk),
        .addr(ram_addr),
        .wr_en(ram_we),
        .wr_data(ram_wdata),
        .rd_data(ram_rdata)
    );

    assign busy = (s_q.exec != clip_pkg::ST_IDLE);
    // Glyph memory sits in the upper half
    always_comb begin
        if (s_q.exec == clip_pkg::ST_FILL) begin
            ram_addr = {1'b0, s_q.fill_ptr};
        end else if (s_q.glyph) begin
            ram_addr = {2'b10, s_q.ac[5:0]};
        end else begin
            ram_addr = {1'b0, s_q.ac};
        end
    end

    // ==========================================================
    // Bus capture
    assign fall = s_q.en && !bus_en;
    always_comb begin
        done = 1'b0;
        byte_v = data_in;
        if (fall) begin
            if (s_q.bw8) begin
                done = 1'b1;
            end else if (s_q.nib_phase) begin
                done = 1'b1;
                byte_v = {s_q.hi_nib, data_in[7:4]};
            end
        end
    end

    assign rd_val = reg_select ? ram_rdata : {busy, s_q.ac};
    assign ram_we = (s_q.exec == clip_pkg::ST_FILL) ||
                    (done && reg_select && !read_write && !busy);
    assign ram_wdata = (s_q.exec == clip_pkg::ST_FILL) ? clip_pkg::SPACE_CODE : byte_v;

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.en = bus_en;
        // Read data follows enable high, one cycle behind
        s_d.oe_n = !(bus_en && read_write);
        if (!s_q.bw8) begin
            s_d.dout = s_q.nib_phase ? {rd_val[3:0], 4'h0} : {rd_val[7:4], 4'h0};
        end else begin
            s_d.dout = rd_val;
        end
        if (fall && !s_q.bw8) begin
            s_d.nib_phase = !s_q.nib_phase;
            if (!s_q.nib_phase) begin
                s_d.hi_nib = data_in[7:4];
            end
        end
        unique case (s_q.exec)
            clip_pkg::ST_IDLE: begin
            end
            clip_pkg::ST_FILL: begin
                s_d.fill_ptr = s_q.fill_ptr + 7'h01;
                s_d.cnt = s_q.cnt - 16'h0001;
                if (s_q.fill_ptr == clip_pkg::FILL_LAST) begin
                    s_d.exec = clip_pkg::ST_WAIT;
                end
            end
            clip_pkg::ST_WAIT: begin
                s_d.cnt = s_q.cnt - 16'h0001;
                if (s_q.cnt == 16'h0000) begin
                    s_d.exec = clip_pkg::ST_IDLE;
                end
            end
        endcase
        // Status reads take no time; all else is ignored while busy
        if (done && !busy && !(!reg_select && read_write)) begin
            s_d.exec = clip_pkg::ST_WAIT;
            // Busy through the count down to zero: N cycles in all
            s_d.cnt = SHORT_N - 16'h0001;
            if (reg_select) begin
                s_d.cnt = DATA_N - 16'h0001;
                s_d.ac = step_addr(s_q.ac, s_q.incr, s_q.glyph, s_q.lines2);
                if (!read_write && s_q.sh_en && !s_q.glyph) begin
                    s_d.shift = s_q.incr ? s_q.shift - 7'h01 : s_q.shift + 7'h01;
                end
            end else if (byte_v[clip_pkg::OP_DISP_ADDR_BIT]) begin
                s_d.ac = byte_v[6:0];
                s_d.glyph = 1'b0;
            end else if (byte_v[clip_pkg::OP_GLYPH_ADDR_BIT]) begin
                s_d.ac = {1'b0, byte_v[5:0]};
                s_d.glyph = 1'b1;
            end else if (byte_v[clip_pkg::OP_FUNC_BIT]) begin
                s_d.bw8 = byte_v[clip_pkg::FUNC_WIDTH_BIT];
                s_d.lines2 = byte_v[clip_pkg::FUNC_LINES_BIT];
                s_d.font = byte_v[clip_pkg::FUNC_FONT_BIT];
                s_d.nib_phase = 1'b0;
            end else if (byte_v[clip_pkg::OP_SHIFT_BIT]) begin
                if (byte_v[clip_pkg::SHIFT_SC_BIT]) begin
                    s_d.shift = byte_v[clip_pkg::SHIFT_RL_BIT] ? s_q.shift + 7'h01
                                                              : s_q.shift - 7'h01;
                end else begin
                    s_d.ac = step_addr(s_q.ac, byte_v[clip_pkg::SHIFT_RL_BIT],
                                       s_q.glyph, s_q.lines2);
                end
            end else if (byte_v[clip_pkg::OP_DISPCTL_BIT]) begin
                s_d.disp_on = byte_v[clip_pkg::DISP_ON_BIT];
                s_d.cur_on = byte_v[clip_pkg::CUR_ON_BIT];
                s_d.blink = byte_v[clip_pkg::BLINK_ON_BIT];
            end else if (byte_v[clip_pkg::OP_ENTRY_BIT]) begin
                s_d.incr = byte_v[clip_pkg::ENTRY_INCR_BIT];
                s_d.sh_en = byte_v[clip_pkg::ENTRY_SHIFT_BIT];
            end else if (byte_v[clip_pkg::OP_HOME_BIT]) begin
                s_d.cnt = LONG_N - 16'h0001;
                s_d.ac = clip_pkg::ADDR_HOME;
                s_d.glyph = 1'b0;
                s_d.shift = 7'h00;
            end else if (byte_v[clip_pkg::OP_CLEAR_BIT]) begin
                s_d.exec = clip_pkg::ST_FILL;
                s_d.cnt = LONG_N - 16'h0001;
                s_d.fill_ptr = 7'h00;
                s_d.ac = clip_pkg::ADDR_HOME;
                s_d.glyph = 1'b0;
                s_d.incr = clip_pkg::RST_INCR;
                s_d.shift = 7'h00;
            end else begin
                // All-zero code is no instruction
                s_d.exec = clip_pkg::ST_IDLE;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{en: 1'b0, nib_phase: 1'b0, hi_nib: 4'h0, exec: clip_pkg::ST_IDLE,
                     cnt: 16'h0000, fill_ptr: 7'h00, ac: 7'h00, glyph: 1'b0,
                     incr: clip_pkg::RST_INCR, sh_en: 1'b0, disp_on: 1'b0,
                     cur_on: 1'b0, blink: 1'b0, bw8: clip_pkg::RST_BUS_WIDTH8,
                     lines2: 1'b0, font: 1'b0, shift: 7'h00, dout: 8'h00, oe_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign data_out = s_q.dout;
    assign data_oe_n = s_q.oe_n;
    assign busy_indication = busy;
    assign address_counter = s_q.ac;
    assign glyph_sel = s_q.glyph;
    assign bus_width_sel = s_q.bw8;
    assign incr_dir = s_q.incr;
    assign whole_display_shift_en = s_q.sh_en;
    assign display_on = s_q.disp_on;
    assign cursor_on = s_q.cur_on;
    assign blink_on = s_q.blink;
    assign two_line = s_q.lines2;
    assign font_sel = s_q.font;
    assign display_shift = s_q.shift;

    // ==========================================================
    // Checks
    localparam int LONG_MIN = 129;
    localparam int SHORT_L = 382;
    logic accept;
    assign accept = done && !busy && !(!reg_select && read_write);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence seq_ctl_accept;
        accept && !reg_select && (byte_v[7:3] == 5'b00001);
    endsequence
    sequence seq_busy_run;
        busy_indication [*8];
    endsequence

    short_exec_a: assert property (seq_ctl_accept |-> ##1 seq_busy_run ##[SHORT_L:SHORT_L] busy_indication ##[1:1] !busy_indication) else $error("short exec length wrong");
    clear_home_a: assert property (accept && !reg_select && byte_v == 8'h01 |=> address_counter == 7'h00 && incr_dir && s_q.exec == clip_pkg::ST_FILL) else $error("clear not started");
    home_reset_a: assert property (accept && !reg_select && byte_v[7:1] == 7'h01 |=> address_counter == 7'h00 && display_shift == 7'h00 ##[LONG_MIN:LONG_MIN] busy_indication) else $error("home wrong");
    entry_store_a: assert property (accept && !reg_select && byte_v[7:2] == 6'h01 |=> incr_dir == $past(byte_v[1]) && whole_display_shift_en == $past(byte_v[0])) else $error("entry mode not stored");
    func_store_a: assert property (accept && !reg_select && byte_v[7:5] == 3'b001 |=> bus_width_sel == $past(byte_v[4]) && two_line == $past(byte_v[3])) else $error("function set not stored");
    addr_load_a: assert property (accept && !reg_select && byte_v[7] |=> address_counter == $past(byte_v[6:0]) && !glyph_sel) else $error("display address not loaded");
    glyph_load_a: assert property (accept && !reg_select && byte_v[7:6] == 2'b01 |=> address_counter == {1'b0, $past(byte_v[5:0])} && glyph_sel) else $error("glyph address not loaded");
    status_read_a: assert property (bus_en && read_write && !reg_select && bus_width_sel |=> data_out == {$past(busy_indication), $past(address_counter)} && !data_oe_n) else $error("status read wrong");
    nibble_wait_a: assert property (fall && !bus_width_sel && !s_q.nib_phase && !busy_indication |=> !busy_indication) else $error("busy after first nibble");
    data_step_a: assert property (accept && reg_select && incr_dir && !glyph_sel && !two_line && address_counter < 7'h4f |=> address_counter == $past(address_counter) + 7'h01) else $error("address not stepped");

endmodule : clip_port

// ===== clip_pkg.sv
// Shared constants and types of the character display instruction port
package clip_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_LONG_NS = 1530000;
    localparam int T_SHORT_NS = 39000;
    localparam int T_DATA_NS = 43000;
    // Execution times are least times, so round up
    localparam int LONG_CYCLES = (T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_CYCLES = (T_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_CYCLES = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Instruction decode: position of the leading one
    localparam int OP_CLEAR_BIT = 0;
    localparam int OP_HOME_BIT = 1;
    localparam int OP_ENTRY_BIT = 2;
    localparam int OP_DISPCTL_BIT = 3;
    localparam int OP_SHIFT_BIT = 4;
    localparam int OP_FUNC_BIT = 5;
    localparam int OP_GLYPH_ADDR_BIT = 6;
    localparam int OP_DISP_ADDR_BIT = 7;
    // Field positions
    localparam int ENTRY_INCR_BIT = 1;
    localparam int ENTRY_SHIFT_BIT = 0;
    localparam int DISP_ON_BIT = 2;
    localparam int CUR_ON_BIT = 1;
    localparam int BLINK_ON_BIT = 0;
    localparam int SHIFT_SC_BIT = 3;
    localparam int SHIFT_RL_BIT = 2;
    localparam int FUNC_WIDTH_BIT = 4;
    localparam int FUNC_LINES_BIT = 3;
    localparam int FUNC_FONT_BIT = 2;

    // ==========================================================
    // Display memory map and fill value
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [6:0] ADDR_HOME = 7'h00;
    localparam logic [6:0] LINE1_END = 7'h27;
    localparam logic [6:0] LINE2_BASE = 7'h40;
    localparam logic [6:0] LINE2_END = 7'h67;
    localparam logic [6:0] ONE_LINE_END = 7'h4f;
    localparam logic [6:0] FILL_LAST = 7'h7f;

    // ==========================================================
    // Reset values
    localparam logic RST_BUS_WIDTH8 = 1'b1;
    localparam logic RST_INCR = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FILL = 3'b010,
        ST_WAIT = 3'b100
    } clip_exec_t;

endpackage : clip_pkg

// ===== clip_ram.sv
// Display and glyph memory with registered read data
`timescale 1ns/1ps
module clip_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock
    input wire logic sys_clk,
    // Access
    input wire logic [AW-1:0] addr,
    input wire logic wr_en,
    input wire logic [DW-1:0] wr_data,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end

endmodule : clip_ram

// ===== clip_host.sv
// Behavioural host processor on the instruction port bus
`timescale 1ns/1ps
module clip_host (
    // Clock
    input wire logic sys_clk,
    // Bus towards the port
    output logic bus_en,
    output logic reg_select,
    output logic read_write,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    // ==========================================================
    // Idle bus at time zero
    initial begin
        bus_en = 1'b0;
        reg_select = 1'b0;
        read_write = 1'b0;
        data_in = 8'h00;
    end

    // ==========================================================
    // One enable cycle, two clocks high so read data has settled
    task cycle(input logic rs, input logic rw, input logic [7:0] d,
               output logic [7:0] q, output logic oe);
        @(negedge sys_clk); // Spare cycle after busy drops, before the next fall
        reg_select = rs;
        read_write = rw;
        data_in = d;
        bus_en = 1'b1;
        @(negedge sys_clk);
        @(negedge sys_clk);
        q = data_out; // Read data taken while enable is still high
        oe = data_oe_n;
        bus_en = 1'b0; // Fall that hands the unit over
        @(negedge sys_clk);
        // Released lines must not look like held data
        data_in = ~d;
    endtask : cycle

    // ==========================================================
    // Whole byte: one cycle wide, or upper then lower nibble on [7:4]
    task xfer(input logic rs, input logic rw, input logic [7:0] d, input logic wide,
              output logic [7:0] q, output logic oe);
        logic [7:0] q1;
        logic [7:0] q2;
        if (wide) begin
            cycle(rs, rw, d, q, oe); // All eight lines in one cycle
        end else begin
            // Junk on the low lines, which the port must ignore
            cycle(rs, rw, {d[7:4], 4'h5}, q1, oe); // Upper nibble first
            cycle(rs, rw, {d[3:0], 4'ha}, q2, oe); // Lower nibble second
            q = {q1[7:4], q2[7:4]};
        end
    endtask : xfer
endmodule : clip_host

// ===== clip_port_tb_top.sv
// Self-checking bench of the instruction port against a host model
`timescale 1ns/1ps
module clip_port_tb_top;
    // Short long-instruction count keeps the run brief
    localparam int LP = 200;
    logic sys_clk;
    logic rst;
    wire logic bus_en, reg_select, read_write, data_oe_n, busy_indication, glyph_sel;
    wire logic bus_width_sel, incr_dir, whole_display_shift_en, display_on, cursor_on;
    wire logic blink_on, two_line, font_sel;
    wire logic [7:0] data_in, data_out;
    wire logic [6:0] address_counter, display_shift;
    logic [7:0] q;
    logic oe;
    int n;
    int n_errors = 0;
    int n_compared = 0;

    clip_port #(.LONG_CYCLES(LP)) clip_port_i (.sys_clk(sys_clk), .rst(rst),
        .bus_en(bus_en), .reg_select(reg_select), .read_write(read_write),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .busy_indication(busy_indication), .address_counter(address_counter),
        .glyph_sel(glyph_sel), .bus_width_sel(bus_width_sel), .incr_dir(incr_dir),
        .whole_display_shift_en(whole_display_shift_en), .display_on(display_on),
        .cursor_on(cursor_on), .blink_on(blink_on), .two_line(two_line),
        .font_sel(font_sel), .display_shift(display_shift));
    clip_host clip_host_i (.sys_clk(sys_clk), .bus_en(bus_en), .reg_select(reg_select),
        .read_write(read_write), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Helpers
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // Count busy cycles, bounded so a lost command cannot hang
    task wait_idle;
        n = 0;
        // First busy cycle is already showing when the transfer returns
        for (int i = 0; i < 1000; i++) begin
            if (busy_indication === 1'b1) n++;
            else if (n > 0) break;
            @(negedge sys_clk);
        end
    endtask : wait_idle

    // Next command only once busy is low
    task cmd(input logic rs, input logic rw, input logic [7:0] d, input logic w = 1'b1);
        clip_host_i.xfer(rs, rw, d, w, q, oe);
        if (rs || !rw) wait_idle();
    endtask : cmd

    // ==========================================================
    // Scenarios
    task t_reset;
        check("busy", 16'(busy_indication), 16'h0000);
        check("width", 16'(bus_width_sel), 16'h0001);
        check("dir", 16'(incr_dir), 16'h0001);
        check("oe_n", 16'(data_oe_n), 16'h0001);
        $display("test reset done");
    endtask : t_reset

    task t_control;
        cmd(1'b0, 1'b0, 8'h38);
        check("busy cycles", 16'(n), 16'h0186);
        check("lines font", 16'({two_line, font_sel, bus_width_sel}), 16'h0005);
        cmd(1'b0, 1'b0, 8'h0d);
        check("disp bits", 16'({display_on, cursor_on, blink_on}), 16'h0005);
        cmd(1'b0, 1'b0, 8'h05);
        check("entry", 16'({incr_dir, whole_display_shift_en}), 16'h0001);
        cmd(1'b0, 1'b0, 8'h06);
        check("entry", 16'({incr_dir, whole_display_shift_en}), 16'h0002);
        $display("test control done");
    endtask : t_control

    task t_data;
        cmd(1'b0, 1'b0, 8'ha7);
        check("addr", 16'({glyph_sel, address_counter}), 16'h0027);
        cmd(1'b1, 1'b0, 8'h5a);
        check("write cycles", 16'(n), 16'h01ae);
        check("addr", 16'(address_counter), 16'h0040);
        cmd(1'b0, 1'b1, 8'h00);
        check("status", 16'(q), 16'h0040);
        check("oe_n", 16'(oe), 16'h0000);
        clip_host_i.xfer(1'b1, 1'b0, 8'h3c, 1'b1, q, oe);
        cmd(1'b0, 1'b1, 8'h00);
        check("status busy", 16'(q), 16'h00c1);
        wait_idle();
        cmd(1'b0, 1'b0, 8'ha7);
        cmd(1'b1, 1'b1, 8'h00);
        check("read data", 16'(q), 16'h005a);
        check("read cycles", 16'(n), 16'h01ae);
        check("addr", 16'(address_counter), 16'h0040);
        cmd(1'b0, 1'b0, 8'h04);
        cmd(1'b0, 1'b0, 8'hc0);
        cmd(1'b1, 1'b0, 8'h77);
        check("addr down", 16'(address_counter), 16'h0027);
        cmd(1'b0, 1'b0, 8'h06);
        $display("test data done");
    endtask : t_data

    task t_glyph;
        cmd(1'b0, 1'b0, 8'h45);
        check("glyph addr", 16'({glyph_sel, address_counter}), 16'h0085);
        cmd(1'b1, 1'b0, 8'h11);
        cmd(1'b0, 1'b0, 8'h45);
        cmd(1'b1, 1'b1, 8'h00);
        check("glyph data", 16'(q), 16'h0011);
        $display("test glyph done");
    endtask : t_glyph

    task t_shift;
        cmd(1'b0, 1'b0, 8'h90);
        cmd(1'b0, 1'b0, 8'h1c);
        check("shift", 16'({display_shift, address_counter}), 16'h0090);
        cmd(1'b0, 1'b0, 8'h14);
        check("cursor", 16'(address_counter), 16'h0011);
        cmd(1'b0, 1'b0, 8'h02);
        check("home cycles", 16'(n), 16'(LP));
        check("home", 16'({display_shift, address_counter}), 16'h0000);
        cmd(1'b0, 1'b0, 8'ha7);
        cmd(1'b1, 1'b1, 8'h00);
        check("kept data", 16'(q), 16'h005a);
        cmd(1'b0, 1'b0, 8'h01);
        check("clear cycles", 16'(n), 16'(LP));
        check("clear addr", 16'(address_counter), 16'h0000);
        cmd(1'b0, 1'b0, 8'ha7);
        cmd(1'b1, 1'b1, 8'h00);
        check("space fill", 16'(q), 16'h0020);
        $display("test shift done");
    endtask : t_shift

    task t_nibble;
        cmd(1'b0, 1'b0, 8'h28);
        check("width", 16'(bus_width_sel), 16'h0000);
        clip_host_i.cycle(1'b0, 1'b0, 8'h0f, q, oe);
        @(negedge sys_clk);
        @(negedge sys_clk);
        check("busy half", 16'({busy_indication, cursor_on}), 16'h0000);
        clip_host_i.cycle(1'b0, 1'b0, 8'hf0, q, oe);
        wait_idle();
        check("busy cycles", 16'(n), 16'h0186);
        check("disp bits", 16'({display_on, cursor_on, blink_on}), 16'h0007);
        cmd(1'b0, 1'b0, 8'h9b, 1'b0);
        cmd(1'b0, 1'b1, 8'h00, 1'b0);
        check("status nibbles", 16'(q), 16'h001b);
        $display("test nibble done");
    endtask : t_nibble

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        rst = 1'b1;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_control();
        t_data();
        t_glyph();
        t_shift();
        t_nibble();
        close_out();
    end

    initial begin
        #5000000;
        n_errors++;
        $display("mismatch watchdog expected done seen hang");
        close_out();
    end
endmodule : clip_port_tb_top
